/* File: shared/spc_pkg.sv */
// Shared constants and types for the status pins and power-down block
//==============================================================
// What this block does
// - Status light polarity: autosense by default, fixed high or fixed low
// - Autosense reads the light pin at reset and picks matching drive
// - Fixed high drives the lamp anode, fixed low drives the cathode
// - Function codes 7 to 10 unusable in automatic blink mode
// - Blink mode 1 takes on and off times from the blink register
// - Blink mode 2 sets duty from measured traffic level
// - Reset defaults: blink mode 1, function link up with traffic
// - Light output enabled at reset, pulled up, separate enable bit
// - Link pin asserted when negotiated link flag is set, except in soft power-down
// - Link pin is sampled as port address bit 2 strap at reset
// - Link pin active high by default, polarity bit inverts it
// - Reset pin low holds hardware power-down: all off, pins released
// - Soft power-down: low power, PLL runs, line ignored, link dropped
// - Soft power-down drives MAC outputs low, registers stay reachable
// - Soft power-down entered from strap at reset or request bit
// - Read-only bit shows soft power-down actually reached
// - Clearing request leaves soft power-down and link bring-up starts
// - All straps sampled right after reset, pins then resume function
// - Strap levels load register reset defaults without software
// - Power-down strap 0 means power down after reset, 1 means not
package spc_pkg;
    //==============================================================
    // Widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int TIME_W = 8;
    localparam int WIN_LOG = 4;
    //==============================================================
    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LIGHT = 8'h01;
    localparam logic [7:0] OFS_POL = 8'h02;
    localparam logic [7:0] OFS_BLINK = 8'h03;
    localparam logic [7:0] OFS_LINK = 8'h04;
    //==============================================================
    // Field positions
    localparam int CT_PD_REQ = 0;
    localparam int CT_SOFT_RST = 1;
    localparam int CT_PD_REACHED = 2;
    localparam int LC_FUNC_LSB = 0;
    localparam int LC_MODE = 4;
    localparam int LC_ENABLE = 7;
    localparam int PL_SEL_LSB = 0;
    localparam int PL_SENSED = 2;
    localparam int BT_OFF_LSB = 0;
    localparam int BT_ON_LSB = 8;
    localparam int LK_POL = 0;
    localparam int LK_ADDR2 = 1;
    localparam int LK_PD_STRAP = 2;
    //==============================================================
    // Encodings
    localparam logic [1:0] POL_AUTO = 2'h0;
    localparam logic [1:0] POL_HIGH = 2'h1;
    localparam logic [1:0] POL_LOW = 2'h2;
    localparam logic MODE_ONE = 1'h0;
    localparam logic MODE_TWO = 1'h1;
    localparam logic [3:0] FN_LINK_TRAFFIC = 4'h0;
    localparam logic [3:0] FN_LINK = 4'h1;
    localparam logic [3:0] FN_TRAFFIC = 4'h2;
    localparam logic [3:0] FN_ON = 4'h7;
    localparam logic [3:0] FN_OFF = 4'h8;
    localparam logic [3:0] FN_FREE = 4'h9;
    localparam logic [3:0] FN_NOLINK = 4'ha;
    localparam logic [3:0] FN_MODE1_LO = 4'h7;
    localparam logic [3:0] FN_MODE1_HI = 4'ha;
    //==============================================================
    // Values after reset
    localparam logic [3:0] FUNC_RST = FN_LINK_TRAFFIC;
    localparam logic MODE_RST = MODE_ONE;
    localparam logic EN_RST = 1'h1;
    localparam logic [1:0] POL_RST = POL_AUTO;
    localparam logic [7:0] ON_RST = 8'h04;
    localparam logic [7:0] OFF_RST = 8'h04;
    localparam logic LINK_POL_RST = 1'h0;
    //==============================================================
    // Timing: one blink step
    localparam int CLK_PERIOD_NS = 50;
    localparam int BLINK_UNIT_NS = 1000000;
    localparam int TICK_CYCLES_DEF = BLINK_UNIT_NS / CLK_PERIOD_NS;
    //==============================================================
    // Start-up sequence
    typedef enum logic [1:0] {
        SPC_HOLD = 2'b00,
        SPC_SAMPLE = 2'b01,
        SPC_RUN = 2'b11
    } spc_seq_t;
endpackage : spc_pkg

/* File: shared/spc_blink_if.sv */
// Control and wave between the top level and the blink generator
`timescale 1ns/1ps
interface spc_blink_if #(parameter int TW = 8);
    logic tick;
    logic mode;
    logic [TW-1:0] onTime;
    logic [TW-1:0] offTime;
    logic active;
    logic wave;
    modport gen(input tick, input mode, input onTime, input offTime, input active,
                output wave);
    modport user(output tick, output mode, output onTime, output offTime,
                 output active, input wave);
endinterface : spc_blink_if

/* File: rtl/spc_blink_gen.sv */
// Blink waveform generator: fixed on/off times or traffic-driven duty
`timescale 1ns/1ps
module spc_blink_gen #(
    parameter int TW = 8,
    parameter int WL = spc_pkg::WIN_LOG
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Control and wave
    spc_blink_if.gen bl
);
    logic phase;
    logic [TW-1:0] stepCnt;
    logic actSeen;
    logic [WL-1:0] winCnt;
    logic [WL:0] actCnt;
    logic [WL:0] level;
    logic wave;
    logic next_phase;
    logic [TW-1:0] next_stepCnt;
    logic next_actSeen;
    logic [WL-1:0] next_winCnt;
    logic [WL:0] next_actCnt;
    logic [WL:0] next_level;
    logic next_wave;

    //==============================================================
    // Step and window counters
    always_comb begin
        next_phase = phase;
        next_stepCnt = stepCnt;
        // Set wins over the tick that clears it
        next_actSeen = bl.active | (actSeen & ~bl.tick);
        next_winCnt = winCnt;
        next_actCnt = actCnt;
        next_level = level;
        if (bl.tick) begin
            // Zero time still lasts one step
            if (stepCnt >= (phase ? bl.onTime : bl.offTime)) begin
                next_phase = ~phase;
                next_stepCnt = '0;
            end else begin
                next_stepCnt = stepCnt + 1'b1;
            end
            next_winCnt = winCnt + 1'b1;
            if (&winCnt) begin
                next_level = actCnt + {{WL{1'b0}}, actSeen};
                next_actCnt = '0;
            end else begin
                next_actCnt = actCnt + {{WL{1'b0}}, actSeen};
            end
        end
        if (bl.mode == spc_pkg::MODE_TWO) begin
            next_wave = {1'b0, winCnt} < level;
        end else begin
            next_wave = phase;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase <= 1'b0;
            stepCnt <= '0;
            actSeen <= 1'b0;
            winCnt <= '0;
            actCnt <= '0;
            level <= '0;
            wave <= 1'b0;
        end else begin
            phase <= next_phase;
            stepCnt <= next_stepCnt;
            actSeen <= next_actSeen;
            winCnt <= next_winCnt;
            actCnt <= next_actCnt;
            level <= next_level;
            wave <= next_wave;
        end
    end

    assign bl.wave = wave;
endmodule : spc_blink_gen

/* File: rtl/spc_status_power.sv */
// Status light, link pin, power-down control and strap capture
`timescale 1ns/1ps
module spc_status_power #(
    parameter int TICK_CYCLES = spc_pkg::TICK_CYCLES_DEF,
    parameter int AW = spc_pkg::ADDR_W,
    parameter int DW = spc_pkg::DATA_W,
    parameter int TW = spc_pkg::TIME_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic resetPinN,
    // Register port
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [DW-1:0] rdData,
    // Core status
    input wire logic negotiatedLinkFlag,
    input wire logic txActive,
    input wire logic rxActive,
    input wire logic macRxValid,
    // Status light pin
    input wire logic lightIn,
    output logic lightOut,
    output logic lightOe,
    // Link indicator pin, address bit 2 strap
    input wire logic linkIn,
    output logic linkOut,
    output logic linkOe,
    // Receive-valid pin, power-down strap
    input wire logic rxValidIn,
    output logic rxValidOut,
    output logic rxValidOe,
    // Core control
    output logic linkEnable,
    output logic pllEnable,
    output logic coreLowPower,
    output logic portAddrBit2
);
    localparam int TCW = $clog2(TICK_CYCLES + 1);

    //==============================================================
    // Declarations
    spc_pkg::spc_seq_t state;
    spc_pkg::spc_seq_t next_state;
    logic [TCW-1:0] tickCnt;
    logic [TCW-1:0] next_tickCnt;
    logic tick;
    logic next_tick;
    logic pdReq;
    logic pdReached;
    logic [3:0] funcSel;
    logic blinkMode;
    logic lightEn;
    logic [1:0] polSel;
    logic sensedActiveLow;
    logic [TW-1:0] onTime;
    logic [TW-1:0] offTime;
    logic linkPol;
    logic addrBit2;
    logic pdStrap;
    logic next_pdReq;
    logic next_pdReached;
    logic [3:0] next_funcSel;
    logic next_blinkMode;
    logic next_lightEn;
    logic [1:0] next_polSel;
    logic next_sensedActiveLow;
    logic [TW-1:0] next_onTime;
    logic [TW-1:0] next_offTime;
    logic next_linkPol;
    logic next_addrBit2;
    logic next_pdStrap;
    logic [DW-1:0] next_rdData;
    logic next_lightOut;
    logic next_lightOe;
    logic next_linkOut;
    logic next_linkOe;
    logic next_rxValidOut;
    logic next_rxValidOe;
    logic next_linkEnable;
    logic next_pllEnable;
    logic next_coreLowPower;
    logic running;
    logic softRstWr;
    logic lit;
    logic activeLow;
    logic traffic;
    logic linkUp;
    logic nextRun;

    spc_blink_if #(.TW(TW)) blink ();

    //==============================================================
    // Register access helpers
    // Hardware power-down: nothing reaches the registers
    assign running = (state == spc_pkg::SPC_RUN) && resetPinN;
    assign softRstWr = running && wrStb && (addr == AW'(spc_pkg::OFS_CTRL))
                       && wrData[spc_pkg::CT_SOFT_RST];
    assign traffic = txActive | rxActive;
    assign linkUp = negotiatedLinkFlag & ~pdReq;

    //==============================================================
    // Start-up sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            spc_pkg::SPC_HOLD: next_state = spc_pkg::SPC_SAMPLE;
            spc_pkg::SPC_SAMPLE: next_state = spc_pkg::SPC_RUN;
            spc_pkg::SPC_RUN: begin
                if (softRstWr) begin
                    next_state = spc_pkg::SPC_HOLD;
                end
            end
            default: next_state = spc_pkg::SPC_HOLD;
        endcase
        if (!resetPinN) begin
            next_state = spc_pkg::SPC_HOLD;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= spc_pkg::SPC_HOLD;
        end else begin
            state <= next_state;
        end
    end

    assign nextRun = (next_state == spc_pkg::SPC_RUN);

    //==============================================================
    // Blink step timer
    always_comb begin
        next_tick = 1'b0;
        next_tickCnt = tickCnt + 1'b1;
        if (tickCnt == TCW'(TICK_CYCLES - 1)) begin
            next_tickCnt = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tickCnt <= '0;
            tick <= 1'b0;
        end else begin
            tickCnt <= next_tickCnt;
            tick <= next_tick;
        end
    end

    //==============================================================
    // Registers and strap capture
    always_comb begin
        next_pdReq = pdReq;
        next_funcSel = funcSel;
        next_blinkMode = blinkMode;
        next_lightEn = lightEn;
        next_polSel = polSel;
        next_sensedActiveLow = sensedActiveLow;
        next_onTime = onTime;
        next_offTime = offTime;
        next_linkPol = linkPol;
        next_addrBit2 = addrBit2;
        next_pdStrap = pdStrap;
        next_pdReached = running && pdReq;
        next_rdData = '0;
        if (state == spc_pkg::SPC_HOLD) begin
            next_funcSel = spc_pkg::FUNC_RST;
            next_blinkMode = spc_pkg::MODE_RST;
            next_lightEn = spc_pkg::EN_RST;
            next_polSel = spc_pkg::POL_RST;
            next_onTime = spc_pkg::ON_RST;
            next_offTime = spc_pkg::OFF_RST;
            next_linkPol = spc_pkg::LINK_POL_RST;
        end else if (state == spc_pkg::SPC_SAMPLE) begin
            // Pull-up still high means lamp hangs from supply
            next_sensedActiveLow = lightIn;
            next_addrBit2 = linkIn;
            next_pdStrap = rxValidIn;
            next_pdReq = ~rxValidIn;
        end else if (running && wrStb) begin
            // Host may overwrite only the strap-derived pdReq; addrBit2, pdStrap and sensed polarity stay
            unique case (addr)
                AW'(spc_pkg::OFS_CTRL): begin
                    next_pdReq = wrData[spc_pkg::CT_PD_REQ];
                end
                AW'(spc_pkg::OFS_LIGHT): begin
                    next_funcSel = wrData[spc_pkg::LC_FUNC_LSB +: 4];
                    next_blinkMode = wrData[spc_pkg::LC_MODE];
                    next_lightEn = wrData[spc_pkg::LC_ENABLE];
                end
                AW'(spc_pkg::OFS_POL): begin
                    next_polSel = wrData[spc_pkg::PL_SEL_LSB +: 2];
                end
                AW'(spc_pkg::OFS_BLINK): begin
                    next_onTime = wrData[spc_pkg::BT_ON_LSB +: TW];
                    next_offTime = wrData[spc_pkg::BT_OFF_LSB +: TW];
                end
                AW'(spc_pkg::OFS_LINK): begin
                    next_linkPol = wrData[spc_pkg::LK_POL];
                end
                default: begin
                end
            endcase
        end
        if (running && rdStb) begin
            // Unmapped offsets read zero
            unique case (addr)
                AW'(spc_pkg::OFS_CTRL): begin
                    next_rdData[spc_pkg::CT_PD_REQ] = pdReq;
                    next_rdData[spc_pkg::CT_PD_REACHED] = pdReached;
                end
                AW'(spc_pkg::OFS_LIGHT): begin
                    next_rdData[spc_pkg::LC_FUNC_LSB +: 4] = funcSel;
                    next_rdData[spc_pkg::LC_MODE] = blinkMode;
                    next_rdData[spc_pkg::LC_ENABLE] = lightEn;
                end
                AW'(spc_pkg::OFS_POL): begin
                    next_rdData[spc_pkg::PL_SEL_LSB +: 2] = polSel;
                    next_rdData[spc_pkg::PL_SENSED] = sensedActiveLow;
                end
                AW'(spc_pkg::OFS_BLINK): begin
                    next_rdData[spc_pkg::BT_ON_LSB +: TW] = onTime;
                    next_rdData[spc_pkg::BT_OFF_LSB +: TW] = offTime;
                end
                AW'(spc_pkg::OFS_LINK): begin
                    next_rdData[spc_pkg::LK_POL] = linkPol;
                    next_rdData[spc_pkg::LK_ADDR2] = addrBit2;
                    next_rdData[spc_pkg::LK_PD_STRAP] = pdStrap;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pdReq <= 1'b1;
            pdReached <= 1'b0;
            funcSel <= spc_pkg::FUNC_RST;
            blinkMode <= spc_pkg::MODE_RST;
            lightEn <= spc_pkg::EN_RST;
            polSel <= spc_pkg::POL_RST;
            sensedActiveLow <= 1'b0;
            onTime <= spc_pkg::ON_RST;
            offTime <= spc_pkg::OFF_RST;
            linkPol <= spc_pkg::LINK_POL_RST;
            addrBit2 <= 1'b0;
            pdStrap <= 1'b0;
            rdData <= '0;
        end else begin
            pdReq <= next_pdReq;
            pdReached <= next_pdReached;
            funcSel <= next_funcSel;
            blinkMode <= next_blinkMode;
            lightEn <= next_lightEn;
            polSel <= next_polSel;
            sensedActiveLow <= next_sensedActiveLow;
            onTime <= next_onTime;
            offTime <= next_offTime;
            linkPol <= next_linkPol;
            addrBit2 <= next_addrBit2;
            pdStrap <= next_pdStrap;
            rdData <= next_rdData;
        end
    end

    //==============================================================
    // Blink generator
    assign blink.tick = tick;
    assign blink.mode = blinkMode;
    assign blink.onTime = onTime;
    assign blink.offTime = offTime;
    assign blink.active = traffic;

    spc_blink_gen #(
        .TW(TW),
        .WL(spc_pkg::WIN_LOG)
    ) u_blink (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .bl(blink)
    );

    //==============================================================
    // Light function select
    always_comb begin
        lit = 1'b0;
        case (funcSel)
            spc_pkg::FN_LINK_TRAFFIC: lit = linkUp & (traffic ? blink.wave : 1'b1);
            spc_pkg::FN_LINK: lit = linkUp;
            spc_pkg::FN_TRAFFIC: lit = traffic & blink.wave;
            spc_pkg::FN_ON: lit = 1'b1;
            spc_pkg::FN_OFF: lit = 1'b0;
            spc_pkg::FN_FREE: lit = blink.wave;
            spc_pkg::FN_NOLINK: lit = ~linkUp;
            default: lit = 1'b0;
        endcase
        // Codes that need fixed timing stay dark in mode 2
        if (blinkMode == spc_pkg::MODE_TWO && funcSel >= spc_pkg::FN_MODE1_LO
            && funcSel <= spc_pkg::FN_MODE1_HI) begin
            lit = 1'b0;
        end
    end

    always_comb begin
        unique case (polSel)
            spc_pkg::POL_HIGH: activeLow = 1'b0;
            spc_pkg::POL_LOW: activeLow = 1'b1;
            default: activeLow = sensedActiveLow;
        endcase
    end

    //==============================================================
    // Pin and core control outputs
    // Built from the next state so pins release on the same edge
    always_comb begin
        next_lightOe = nextRun && lightEn;
        next_lightOut = lit ^ activeLow;
        next_linkOe = nextRun;
        next_linkOut = linkUp ^ linkPol;
        next_rxValidOe = nextRun;
        next_rxValidOut = macRxValid & ~pdReq;
        next_linkEnable = nextRun && !pdReq;
        next_pllEnable = (next_state != spc_pkg::SPC_HOLD);
        next_coreLowPower = !nextRun || pdReq;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lightOut <= 1'b0;
            lightOe <= 1'b0;
            linkOut <= 1'b0;
            linkOe <= 1'b0;
            rxValidOut <= 1'b0;
            rxValidOe <= 1'b0;
            linkEnable <= 1'b0;
            pllEnable <= 1'b0;
            coreLowPower <= 1'b1;
            portAddrBit2 <= 1'b0;
        end else begin
            lightOut <= next_lightOut;
            lightOe <= next_lightOe;
            linkOut <= next_linkOut;
            linkOe <= next_linkOe;
            rxValidOut <= next_rxValidOut;
            rxValidOe <= next_rxValidOe;
            linkEnable <= next_linkEnable;
            pllEnable <= next_pllEnable;
            coreLowPower <= next_coreLowPower;
            portAddrBit2 <= next_addrBit2;
        end
    end
endmodule : spc_status_power

/* File: test/spc_pin_model.sv */
// Pin-side partner: resistors, straps and pin levels
`timescale 1ns/1ps
module spc_pin_model (
    // Drives from the block
    input wire logic lightOut,
    input wire logic lightOe,
    input wire logic linkOut,
    input wire logic linkOe,
    input wire logic rxValidOut,
    input wire logic rxValidOe,
    // Strap levels set by the bench
    input wire logic strapLink,
    input wire logic strapPd,
    // Resolved pin levels
    output logic lightIn,
    output logic linkIn,
    output logic rxValidIn
);
    //==========================================
    // Pin resolution
    assign lightIn = lightOe ? lightOut : 1'b1;
    assign linkIn = linkOe ? linkOut : strapLink;
    assign rxValidIn = rxValidOe ? rxValidOut : strapPd;
endmodule : spc_pin_model

/* File: test/spc_status_power_chk.sv */
// Port assertions for the status pins and power-down block
`timescale 1ns/1ps
module spc_status_power_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic resetPinN,
    // Register port
    input wire logic rdStb,
    input wire logic [15:0] rdData,
    // Pins and core control
    input wire logic linkIn,
    input wire logic linkOe,
    input wire logic lightOe,
    input wire logic rxValidOe,
    input wire logic pllEnable,
    input wire logic coreLowPower,
    input wire logic linkEnable,
    input wire logic portAddrBit2
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    //==========================================
    // Checks
    chk_hold_pins: assert property ((!resetPinN)[*3] |-> !linkOe && !lightOe && !rxValidOe)
        else $error("pins driven in hardware power-down");
    chk_hold_core: assert property ((!resetPinN)[*3] |-> !pllEnable && coreLowPower && !linkEnable)
        else $error("core active in hardware power-down");
    chk_rd_idle: assert property (!$past(rdStb) |-> rdData == 16'h0000)
        else $error("read data outside answer cycle");
    chk_rd_refused: assert property (!resetPinN && rdStb |=> rdData == 16'h0000)
        else $error("register read in hardware power-down");
    chk_oe_start: assert property ($fell(sys_rst) && resetPinN |-> !linkOe ##2 linkOe)
        else $error("pins not released on time after reset");
    chk_addr_strap: assert property ($rose(linkOe) |-> portAddrBit2 == $past(linkIn))
        else $error("address strap not captured");
    chk_addr_stable: assert property (linkOe && $past(linkOe) |-> $stable(portAddrBit2))
        else $error("address strap changed while running");
    chk_pins_together: assert property ($rose(linkOe) |-> $rose(rxValidOe))
        else $error("strap pins resumed at different times");
endmodule : spc_status_power_chk

bind spc_status_power spc_status_power_chk chk_u (.ref_clk, .sys_rst, .resetPinN, .rdStb, .rdData,
    .linkIn, .linkOe, .lightOe, .rxValidOe, .pllEnable, .coreLowPower, .linkEnable, .portAddrBit2);

/* File: test/spc_status_power_tb.sv */
// Self-checking bench for the status pins and power-down block
`timescale 1ns/1ps
module spc_status_power_tb;
    typedef struct packed {logic wr; logic [7:0] a; logic [15:0] d; logic [15:0] e;} spc_row_t;
    logic ref_clk = 0, sys_rst = 1, resetPinN = 1, wrStb = 0, rdStb = 0, macRxValid = 1;
    logic negotiatedLinkFlag = 0, txActive = 0, rxActive = 0, strapLink = 1, strapPd = 1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wrData = 16'h0000;
    logic [15:0] rdData;
    logic lightIn, lightOut, lightOe, linkIn, linkOut, linkOe, rxValidIn, rxValidOut;
    logic rxValidOe, linkEnable, pllEnable, coreLowPower, portAddrBit2, lvl;
    int errors = 0, comparisons = 0, i;
    spc_row_t rows[10] = '{
        '{1'b0, 8'h00, 16'h0000, 16'h0000}, '{1'b0, 8'h01, 16'h0000, 16'h0080},
        '{1'b0, 8'h02, 16'h0000, 16'h0004}, '{1'b0, 8'h03, 16'h0000, 16'h0404},
        '{1'b0, 8'h04, 16'h0000, 16'h0006}, '{1'b1, 8'h01, 16'h0093, 16'h0093},
        '{1'b1, 8'h03, 16'h0302, 16'h0302}, '{1'b1, 8'h04, 16'h0000, 16'h0006},
        '{1'b1, 8'h10, 16'hffff, 16'h0000}, '{1'b1, 8'h02, 16'h0002, 16'h0006}};

    always #25 ref_clk = ~ref_clk;

    // Short blink step keeps blink tests fast
    spc_status_power #(.TICK_CYCLES(4)) dut_u (.ref_clk, .sys_rst, .resetPinN, .addr, .wrData,
        .wrStb, .rdStb, .rdData, .negotiatedLinkFlag, .txActive, .rxActive, .macRxValid,
        .lightIn, .lightOut, .lightOe, .linkIn, .linkOut, .linkOe, .rxValidIn, .rxValidOut,
        .rxValidOe, .linkEnable, .pllEnable, .coreLowPower, .portAddrBit2);
    spc_pin_model pin_u (.lightOut, .lightOe, .linkOut, .linkOe, .rxValidOut, .rxValidOe,
        .strapLink, .strapPd, .lightIn, .linkIn, .rxValidIn);

    //==========================================
    // Tasks
    task automatic test_done;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic cmpReg(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t register got %h expected %h", $time, got, exp);
        end
    endtask : cmpReg
    task automatic cmpPin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t pin got %b expected %b", $time, got, exp);
        end
    endtask : cmpPin
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge ref_clk);
        wrStb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge ref_clk);
        rdStb <= 1'b0;
        #1;
        cmpReg(rdData, e);
    endtask : rd
    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle
    // Oe drops first, so a restart is never mistaken for running
    task automatic waitRun;
        repeat (2) @(posedge ref_clk);
        for (i = 0; i < 40 && rxValidOe !== 1'b1; i++) @(posedge ref_clk);
        if (rxValidOe !== 1'b1) begin
            errors++;
            $display("[ERR] %0t start-up timed out", $time);
            test_done();
        end
    endtask : waitRun

    //==========================================
    // Sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        waitRun();
        foreach (rows[k]) begin
            if (rows[k].wr) wr(rows[k].a, rows[k].d);
            rd(rows[k].a, rows[k].e);
        end
        @(posedge ref_clk) negotiatedLinkFlag <= 1'b1;
        settle();
        cmpPin(linkOut, 1'b1);
        wr(8'h04, 16'h0001);
        settle();
        cmpPin(linkOut, 1'b0);
        wr(8'h04, 16'h0000);
        wr(8'h02, 16'h0001);
        wr(8'h01, 16'h0087);
        settle();
        cmpPin(lightOut, 1'b1);
        wr(8'h02, 16'h0002);
        settle();
        cmpPin(lightOut, 1'b0);
        wr(8'h02, 16'h0001);
        wr(8'h01, 16'h0097);
        settle();
        cmpPin(lightOut, 1'b0);
        @(posedge ref_clk) txActive <= 1'b1;
        wr(8'h03, 16'h0000);
        wr(8'h01, 16'h0082);
        settle();
        lvl = lightOut;
        repeat (2) settle();
        cmpPin(lightOut, ~lvl);
        wr(8'h01, 16'h0092);
        // Two full activity windows before the duty is judged
        repeat (80) settle();
        cmpPin(lightOut, 1'b1);
        wr(8'h01, 16'h0007);
        settle();
        cmpPin(lightOe, 1'b0);
        wr(8'h00, 16'h0001);
        settle();
        rd(8'h00, 16'h0005);
        cmpPin(linkOut, 1'b0);
        cmpPin(linkEnable, 1'b0);
        cmpPin(pllEnable, 1'b1);
        cmpPin(coreLowPower, 1'b1);
        cmpPin(rxValidOut, 1'b0);
        wr(8'h00, 16'h0000);
        settle();
        cmpPin(linkEnable, 1'b1);
        cmpPin(coreLowPower, 1'b0);
        strapPd <= 1'b0;
        strapLink <= 1'b0;
        wr(8'h00, 16'h0002);
        waitRun();
        rd(8'h00, 16'h0005);
        wr(8'h00, 16'h0000);
        rd(8'h00, 16'h0000);
        rd(8'h04, 16'h0000);
        rd(8'h01, 16'h0080);
        cmpPin(portAddrBit2, 1'b0);
        @(posedge ref_clk) resetPinN <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(8'h01, 16'h0000);
        cmpPin(pllEnable, 1'b0);
        strapPd <= 1'b1;
        @(posedge ref_clk) resetPinN <= 1'b1;
        waitRun();
        rd(8'h00, 16'h0000);
        test_done();
    end
endmodule : spc_status_power_tb
